// file: bench/dios_chk_sva.sv
// Port checker for the digital I/O channel supervisor
module dios_chk #(parameter CH = 8, CW = 26, SAVE_TICKS = 20) (
    // Clock, reset and bus
    input logic              clk, rst_b, hsel, hwrite, hready, hreadyout, hresp,
    input logic [1:0]        htrans,
    input logic [31:0]       hrdata,
    // Field and store
    input logic              comm_fault, comm_idle, nv_save_pulse,
    input logic [CH-1:0]     dout,
    input logic [CH*CW-1:0]  nv_save_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Cycles since the last save; the first pulse after reset has no reference
    logic [31:0] gap;
    logic        seen;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap  <= 32'h0;
            seen <= 1'b0;
        end else if (nv_save_pulse) begin
            gap  <= 32'h0;
            seen <= 1'b1;
        end else begin
            gap  <= gap + 32'h1;
        end
    end
    sequence s_fault_held; comm_fault [*3]; endsequence
    sequence s_idle_held; (comm_idle && !comm_fault) [*3]; endsequence
    property p_ready; hreadyout; endproperty
    property p_okay; !hresp; endproperty
    property p_rdata; $changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite); endproperty
    property p_fault_act; s_fault_held |-> $stable(dout); endproperty
    property p_idle_act; s_idle_held |-> $stable(dout); endproperty
    property p_save_pulse; nv_save_pulse |=> !nv_save_pulse [*8]; endproperty
    property p_save_gap; nv_save_pulse && seen |-> gap == SAVE_TICKS * 2000 - 1; endproperty
    property p_save_snap; $changed(nv_save_count) |-> nv_save_pulse; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_rdata: assert property (p_rdata) else $error("hrdata moved without read");
    a_fault_act: assert property (p_fault_act) else $error("dout moved in fault");
    a_idle_act: assert property (p_idle_act) else $error("dout moved in idle");
    a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
    a_save_gap: assert property (p_save_gap) else $error("save period wrong");
    a_save_snap: assert property (p_save_snap) else $error("snapshot moved");
endmodule // dios_chk

// file: bench/dios_field_model.sv
// Field devices, fieldbus state and non-volatile count store
module dios_field_model #(parameter CH = 8, CW = 26) (
    // Clock and save side
    input logic              clk, nv_save_pulse,
    input logic [CH*CW-1:0]  nv_save_count,
    // Field and fieldbus
    output logic             comm_fault, comm_idle, load_short_pin, supply_short_pin,
    output logic [CH-1:0]    din_pin, open_wire_pin,
    // Restore side
    output logic             nv_restore_load,
    output logic [CH*CW-1:0] nv_restore_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CH*CW-1:0] nv_store;
    initial begin
        {comm_fault, comm_idle, load_short_pin, supply_short_pin} = 4'h0;
        {din_pin, open_wire_pin, nv_restore_load} = '0;
        nv_store = '0;
        nv_restore_count = '1;
    end
    // Store is not cleared by device reset, as flash would not be
    always @(posedge clk) begin
        if (nv_save_pulse) nv_store <= nv_save_count;
    end
    task restore;
        @(posedge clk);
        nv_restore_count <= nv_store;
        nv_restore_load <= 1'b1;
        @(posedge clk);
        nv_restore_load <= 1'b0;
        // Released bus shows junk so a late load cannot pass by luck
        nv_restore_count <= ~nv_store;
    endtask
endmodule // dios_field_model

// file: bench/dios_top_tb.sv
// Self-checking bench for the digital I/O channel supervisor
`include "dios_consts.vh"
module dios_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam CH = 8;
    localparam CW = 26;
    logic              clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic              comm_fault, comm_idle, load_short_pin, supply_short_pin;
    logic              nv_save_pulse, nv_restore_load;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata, hrdata, rd, r;
    logic [CH-1:0]     din_pin, open_wire_pin, dout, out_v;
    logic [CH*CW-1:0]  nv_restore_count, nv_save_count;
    logic [15:0]       fa, ia;
    int                mismatches, tests_run, cnt;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    dios_top #(.SAVE_TICKS(2)) dios_top_inst (.clk, .rst_b, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .comm_fault, .comm_idle, .din_pin, .open_wire_pin, .load_short_pin,
        .supply_short_pin, .dout, .nv_restore_load, .nv_restore_count,
        .nv_save_pulse, .nv_save_count);
    dios_field_model #(.CH(CH), .CW(CW)) dios_field_model_inst (.clk, .nv_save_pulse,
        .nv_save_count, .comm_fault, .comm_idle, .load_short_pin, .supply_short_pin,
        .din_pin, .open_wire_pin, .nv_restore_load, .nv_restore_count);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One single transfer; the next one starts a cycle later
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task pins(input logic ls, input logic ss);
        dios_field_model_inst.load_short_pin <= ls;
        dios_field_model_inst.supply_short_pin <= ss;
        repeat (6) @(posedge clk);
    endtask
    task do_reset;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    function logic [CH-1:0] act(input logic [CH-1:0] o, input logic [15:0] c);
        for (int i = 0; i < CH; i++)
            act[i] = (c[2*i+:2] == 2'h1) ? o[i] : (c[2*i+:2] == 2'h2);
    endfunction
    task give_verdict;
        $display("counts: %0d mismatches, %0d comparisons", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        r = $urandom(46427);
        do_reset;
        rdchk(`DIOS_OFS_CTRL, 32'h509);
        rdchk(`DIOS_OFS_LIMIT, 32'h1);
        rdchk(`DIOS_OFS_STATUS, 32'h0);
        $display("test reset values done");
        pins(1'b1, 1'b0);
        rdchk(`DIOS_OFS_STATUS, 32'h1);
        pins(1'b0, 1'b0);
        rdchk(`DIOS_OFS_STATUS, 32'h0);
        wr(`DIOS_OFS_CTRL, 32'h10B);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        rdchk(`DIOS_OFS_STATUS, 32'h1);
        wr(`DIOS_OFS_CTRL, 32'h108);
        pins(1'b1, 1'b1);
        rdchk(`DIOS_OFS_STATUS, 32'h2);
        wr(`DIOS_OFS_CTRL, 32'h100);
        rdchk(`DIOS_OFS_STATUS, 32'h0);
        pins(1'b0, 1'b0);
        r = $urandom;
        dios_field_model_inst.open_wire_pin <= r[CH-1:0];
        rdchk(`DIOS_OFS_OPEN_ERR, 32'h0);
        wr(`DIOS_OFS_CTRL, 32'h104);
        rdchk(`DIOS_OFS_OPEN_ERR, {24'h0, r[CH-1:0]});
        $display("test error flags done");
        wr(`DIOS_OFS_CTRL, 32'h149);
        for (cnt = 1; cnt <= 1001; cnt++) begin
            wr(`DIOS_OFS_OUT_DATA, 32'h1);
            wr(`DIOS_OFS_OUT_DATA, 32'h0);
            if (cnt == 1000) rdchk(`DIOS_OFS_CNT_ERR, 32'h0);
        end
        rdchk(`DIOS_OFS_CNT_ERR, 32'h1);
        rdchk(`DIOS_OFS_COUNT, 32'h3E9);
        // Let one save period pass so the store holds the final count
        repeat (4200) @(posedge clk);
        do_reset;
        dios_field_model_inst.restore;
        rdchk(`DIOS_OFS_COUNT, 32'h3E9);
        $display("test on-count done");
        // A turn-on opens the inrush window, which hides a load short
        wr(`DIOS_OFS_CTRL, 32'h119);
        wr(`DIOS_OFS_OUT_DATA, 32'h1);
        pins(1'b1, 1'b0);
        rdchk(`DIOS_OFS_STATUS, 32'h4);
        wr(`DIOS_OFS_CTRL, 32'h109);
        rdchk(`DIOS_OFS_STATUS, 32'h1);
        pins(1'b0, 1'b0);
        $display("test inrush window done");
        r = $urandom | 32'h1;
        dios_field_model_inst.din_pin <= r[CH-1:0];
        repeat (12000) @(posedge clk);
        dios_field_model_inst.din_pin <= '0;
        repeat (4000) @(posedge clk);
        rdchk(`DIOS_OFS_INPUT, 32'h0);
        dios_field_model_inst.din_pin <= r[CH-1:0];
        repeat (24000) @(posedge clk);
        rdchk(`DIOS_OFS_INPUT, {24'h0, r[CH-1:0]});
        // Fastest filter, so the fall passes within a tick and the stretch shows alone
        wr(`DIOS_OFS_CTRL, 32'h009);
        dios_field_model_inst.din_pin <= '0;
        repeat (10000) @(posedge clk);
        rdchk(`DIOS_OFS_INPUT, {24'h0, r[CH-1:0]});
        repeat (14000) @(posedge clk);
        rdchk(`DIOS_OFS_INPUT, 32'h0);
        $display("test input filter done");
        wr(`DIOS_OFS_CTRL, 32'h129);
        for (cnt = 0; cnt < 3; cnt++) begin
            r = $urandom;
            {ia, fa} = r;
            r = $urandom;
            out_v = r[CH-1:0];
            wr(`DIOS_OFS_OUT_DATA, {24'h0, out_v});
            wr(`DIOS_OFS_FAULT_ACT, {16'h0, fa});
            wr(`DIOS_OFS_IDLE_ACT, {16'h0, ia});
            chk(dout, out_v);
            dios_field_model_inst.comm_fault <= (cnt != 1);
            dios_field_model_inst.comm_idle <= (cnt != 0);
            repeat (4) @(posedge clk);
            chk(dout, act(out_v, cnt == 1 ? ia : fa));
            {dios_field_model_inst.comm_fault, dios_field_model_inst.comm_idle} <= 2'h0;
            repeat (2) @(posedge clk);
        end
        wr(`DIOS_OFS_FAULT_ACT, 32'hAAAA);
        wr(`DIOS_OFS_CTRL, 32'h109);
        dios_field_model_inst.comm_fault <= 1'b1;
        repeat (4) @(posedge clk);
        chk(dout, 8'h0);
        dios_field_model_inst.comm_fault <= 1'b0;
        $display("test output actions done");
        give_verdict;
    end
endmodule // dios_top_tb
bind dios_top dios_chk #(.CH(CH), .CW(CW), .SAVE_TICKS(SAVE_TICKS)) dios_chk_inst (.clk, .rst_b,
    .hsel, .hwrite, .hready, .hreadyout, .hresp, .htrans, .hrdata, .comm_fault, .comm_idle,
    .nv_save_pulse, .dout, .nv_save_count);

// file: hw/dios_consts.vh
// Constants for the digital I/O channel supervisor
`ifndef DIOS_CONSTS_VH
`define DIOS_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DIOS_OFS_CTRL      8'h00
`define DIOS_OFS_FAULT_ACT 8'h04
`define DIOS_OFS_IDLE_ACT  8'h08
`define DIOS_OFS_LIMIT     8'h0C
`define DIOS_OFS_OUT_DATA  8'h10
`define DIOS_OFS_STATUS    8'h14
`define DIOS_OFS_OPEN_ERR  8'h18
`define DIOS_OFS_CNT_ERR   8'h1C
`define DIOS_OFS_INPUT     8'h20
`define DIOS_OFS_DOUT      8'h24
`define DIOS_OFS_COUNT     8'h40

// ****************************************
// Control register fields
// ****************************************
`define DIOS_CTL_LS_EN   0
`define DIOS_CTL_LS_MAN  1
`define DIOS_CTL_OW_EN   2
`define DIOS_CTL_SS_EN   3
`define DIOS_CTL_INR_EN  4
`define DIOS_CTL_TERM    5
`define DIOS_CTL_LIM_EN  6
`define DIOS_CTL_FILT_LO 8
`define DIOS_CTL_STR_LO  10
`define DIOS_CTL_W       12
`define DIOS_CTL_RST     12'h509

// ****************************************
// Status register fields
// ****************************************
`define DIOS_ST_LS  0
`define DIOS_ST_SS  1
`define DIOS_ST_INR 2

// ****************************************
// Output actions and reset values
// ****************************************
`define DIOS_ACT_CLEAR 2'h0
`define DIOS_ACT_HOLD  2'h1
`define DIOS_ACT_FORCE 2'h2
`define DIOS_LIMIT_RST 16'h0001
`define DIOS_LIMIT_SCALE 26'h00003E8

// ****************************************
// Timing, in ns and in 0.1 ms ticks
// ****************************************
`define DIOS_CLK_NS     50
`define DIOS_TICK_NS    100000
`define DIOS_FILT_T0    12'h001
`define DIOS_FILT_T1    12'h00A
`define DIOS_FILT_T2    12'h064
`define DIOS_FILT_T3    12'h0C8
`define DIOS_STR_T0     12'h00A
`define DIOS_STR_T1     12'h096
`define DIOS_STR_T2     12'h3E8
`define DIOS_STR_T3     12'h7D0
`define DIOS_INRUSH_T   12'h3E8
`define DIOS_SAVE_TICKS 36000000

`endif

// file: hw/dios_top.v
// Digital I/O channel supervisor with AHB-Lite register slave
// Function
// - Load short monitor enabled raises unit error on short; disabled raises none.
// - Auto restart clears load short error once the short disappears.
// - Manual restart keeps load short error latched until reset or until the monitor is disabled.
// - Open wire monitor flags per-channel error; disabled by default.
// - On comm fault each output clears, holds or drives on per its action.
// - While comm idles without a fault each output follows its own idle action.
// - Fault and idle actions apply only with terminal priority selected.
// - Count output turn-ons; flag channel error above limit times 1000.
// - Save counts hourly to non-volatile store; resume from restored value.
// - Supply short monitor enabled raises unit error on supply short.
// - Inrush filter ignores overcurrent for 100 ms after inrush.
// - Reject input changes shorter than selected filter time, default 1 ms.
// - Stretch detected inputs by selected hold time, default 15 ms.
`include "dios_consts.vh"

module dios_top #(
    parameter CH          = 8,
    parameter CW          = 26,
    parameter SAVE_TICKS  = `DIOS_SAVE_TICKS
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // AHB-Lite slave
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output wire             hreadyout,
    output wire             hresp,
    output reg  [31:0]      hrdata,
    // Fieldbus state
    input  wire             comm_fault,
    input  wire             comm_idle,
    // Field pins
    input  wire [CH-1:0]    din_pin,
    input  wire [CH-1:0]    open_wire_pin,
    input  wire             load_short_pin,
    input  wire             supply_short_pin,
    output reg  [CH-1:0]    dout,
    // Non-volatile count store
    input  wire             nv_restore_load,
    input  wire [CH*CW-1:0] nv_restore_count,
    output reg              nv_save_pulse,
    output reg  [CH*CW-1:0] nv_save_count
);

// ****************************************
// Reset release and derived timing
// ****************************************
localparam TICK_CYC = `DIOS_TICK_NS / `DIOS_CLK_NS;

reg        rst_m_b;
reg        rst_s_b;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_m_b <= 1'b0;
        rst_s_b <= 1'b0;
    end else begin
        rst_m_b <= 1'b1;
        rst_s_b <= rst_m_b;
    end
end

// ****************************************
// Pin synchronisers
// ****************************************
reg [CH+CH+1:0] pin_m;
reg [CH+CH+1:0] pin_s;

always @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
        pin_m <= {(CH+CH+2){1'b0}};
        pin_s <= {(CH+CH+2){1'b0}};
    end else begin
        pin_m <= {supply_short_pin, load_short_pin, open_wire_pin, din_pin};
        pin_s <= pin_m;
    end
end

wire [CH-1:0] din_s   = pin_s[CH-1:0];
wire [CH-1:0] open_s  = pin_s[CH+CH-1:CH];
wire          lshort_s = pin_s[CH+CH];
wire          sshort_s = pin_s[CH+CH+1];

// ****************************************
// Registers
// ****************************************
reg [`DIOS_CTL_W-1:0] ctrl;
reg [2*CH-1:0]        fault_act;
reg [2*CH-1:0]        idle_act;
reg [15:0]            limit;
reg [CH-1:0]          out_data;
reg                   err_ls;
reg                   err_ss;
reg [CH-1:0]          err_ow;
wire [CH-1:0]         err_cnt;
wire [CH-1:0]         din_out;
wire [CH*CW-1:0]      cnt_flat;
wire                  inr_act;

wire ls_en   = ctrl[`DIOS_CTL_LS_EN];
wire ls_man  = ctrl[`DIOS_CTL_LS_MAN];
wire ow_en   = ctrl[`DIOS_CTL_OW_EN];
wire ss_en   = ctrl[`DIOS_CTL_SS_EN];
wire inr_en  = ctrl[`DIOS_CTL_INR_EN];
wire term    = ctrl[`DIOS_CTL_TERM];
wire lim_en  = ctrl[`DIOS_CTL_LIM_EN];
wire [1:0] filt_sel = ctrl[`DIOS_CTL_FILT_LO+1:`DIOS_CTL_FILT_LO];
wire [1:0] str_sel  = ctrl[`DIOS_CTL_STR_LO+1:`DIOS_CTL_STR_LO];

// ****************************************
// AHB-Lite slave
// ****************************************
// Zero wait states: read data is prepared during the address phase
reg        wr_pend;
reg [7:0]  wr_addr;
wire       acc   = hsel & htrans[1] & hready;
wire [7:0] a_ofs = haddr[7:0];
wire [2:0] c_idx = a_ofs[4:2];

assign hreadyout = 1'b1;
assign hresp     = 1'b0;

reg [31:0] rd_val;
always @* begin
    rd_val = 32'h00000000;
    case (a_ofs)
        `DIOS_OFS_CTRL:      rd_val[`DIOS_CTL_W-1:0] = ctrl;
        `DIOS_OFS_FAULT_ACT: rd_val[2*CH-1:0] = fault_act;
        `DIOS_OFS_IDLE_ACT:  rd_val[2*CH-1:0] = idle_act;
        `DIOS_OFS_LIMIT:     rd_val[15:0] = limit;
        `DIOS_OFS_OUT_DATA:  rd_val[CH-1:0] = out_data;
        `DIOS_OFS_STATUS: begin
            rd_val[`DIOS_ST_LS] = err_ls;
            rd_val[`DIOS_ST_SS] = err_ss;
            rd_val[`DIOS_ST_INR] = inr_act;
        end
        `DIOS_OFS_OPEN_ERR:  rd_val[CH-1:0] = err_ow;
        `DIOS_OFS_CNT_ERR:   rd_val[CH-1:0] = err_cnt;
        `DIOS_OFS_INPUT:     rd_val[CH-1:0] = din_out;
        `DIOS_OFS_DOUT:      rd_val[CH-1:0] = dout;
        default: begin
            if ((a_ofs & 8'hE0) == `DIOS_OFS_COUNT && c_idx < CH) begin
                rd_val[CW-1:0] = cnt_flat[c_idx*CW +: CW];
            end
        end
    endcase
end

always @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
        wr_pend   <= 1'b0;
        wr_addr   <= 8'h00;
        hrdata    <= 32'h00000000;
        ctrl      <= `DIOS_CTL_RST;
        fault_act <= {CH{`DIOS_ACT_CLEAR}};
        idle_act  <= {CH{`DIOS_ACT_CLEAR}};
        limit     <= `DIOS_LIMIT_RST;
        out_data  <= {CH{1'b0}};
    end else begin
        wr_pend <= acc & hwrite;
        wr_addr <= a_ofs;
        if (acc & ~hwrite) begin
            hrdata <= rd_val;
        end
        if (wr_pend) begin
            case (wr_addr)
                `DIOS_OFS_CTRL:      ctrl      <= hwdata[`DIOS_CTL_W-1:0];
                `DIOS_OFS_FAULT_ACT: fault_act <= hwdata[2*CH-1:0];
                `DIOS_OFS_IDLE_ACT:  idle_act  <= hwdata[2*CH-1:0];
                `DIOS_OFS_LIMIT:     limit     <= hwdata[15:0];
                `DIOS_OFS_OUT_DATA:  out_data  <= hwdata[CH-1:0];
                default: ;
            endcase
        end
    end
end

// ****************************************
// 0.1 ms tick and hourly save timer
// ****************************************
reg [11:0] tick_cnt;
reg        tick;
reg [31:0] save_cnt;

always @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
        tick_cnt      <= 12'h000;
        tick          <= 1'b0;
        save_cnt      <= 32'h00000000;
        nv_save_pulse <= 1'b0;
        nv_save_count <= {(CH*CW){1'b0}};
    end else begin
        tick          <= 1'b0;
        nv_save_pulse <= 1'b0;
        if (tick_cnt == TICK_CYC - 1) begin
            tick_cnt <= 12'h000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 12'h001;
        end
        if (tick) begin
            if (save_cnt == SAVE_TICKS - 1) begin
                save_cnt      <= 32'h00000000;
                nv_save_pulse <= 1'b1;
                nv_save_count <= cnt_flat;
            end else begin
                save_cnt <= save_cnt + 32'h00000001;
            end
        end
    end
end

// ****************************************
// Inrush window and unit errors
// ****************************************
// Any output switching on opens the window; lamp loads draw surge current
reg  [CH-1:0] dout_q;
reg  [11:0]   inr_cnt;
wire [CH-1:0] rise    = dout & ~dout_q;
assign inr_act = inr_en & (inr_cnt != 12'h000);

always @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
        dout_q  <= {CH{1'b0}};
        inr_cnt <= 12'h000;
        err_ls  <= 1'b0;
        err_ss  <= 1'b0;
        err_ow  <= {CH{1'b0}};
    end else begin
        dout_q <= dout;
        if (|rise) begin
            inr_cnt <= `DIOS_INRUSH_T;
        end else if (tick && inr_cnt != 12'h000) begin
            inr_cnt <= inr_cnt - 12'h001;
        end
        if (!ls_en) begin
            err_ls <= 1'b0;
        end else if (lshort_s && !inr_act) begin
            err_ls <= 1'b1;
        end else if (!lshort_s && !ls_man) begin
            err_ls <= 1'b0;
        end
        // Manual mode leaves err_ls set until reset or until ls_en is cleared
        err_ss <= ss_en & sshort_s & ~inr_act;
        err_ow <= {CH{ow_en}} & open_s;
    end
end

// ****************************************
// Per-channel logic
// ****************************************
wire [CW-1:0] lim_full = limit * `DIOS_LIMIT_SCALE;

reg [11:0] filt_t;
reg [11:0] str_t;
always @* begin
    case (filt_sel)
        2'h0:    filt_t = `DIOS_FILT_T0;
        2'h1:    filt_t = `DIOS_FILT_T1;
        2'h2:    filt_t = `DIOS_FILT_T2;
        default: filt_t = `DIOS_FILT_T3;
    endcase
    case (str_sel)
        2'h0:    str_t = `DIOS_STR_T0;
        2'h1:    str_t = `DIOS_STR_T1;
        2'h2:    str_t = `DIOS_STR_T2;
        default: str_t = `DIOS_STR_T3;
    endcase
end

genvar i;
generate
    for (i = 0; i < CH; i = i + 1) begin : g_ch
        reg  [CW-1:0] cnt;
        reg  [11:0]   flt_cnt;
        reg           flt;
        reg  [11:0]   str_cnt;
        reg           next_out;
        wire [1:0]    f_act = fault_act[2*i+1:2*i];
        wire [1:0]    i_act = idle_act[2*i+1:2*i];
        wire [1:0]    act   = comm_fault ? f_act : i_act;

        // Without terminal priority a fault or idle simply clears
        always @* begin
            next_out = out_data[i];
            if (comm_fault || comm_idle) begin
                next_out = 1'b0;
                if (term) begin
                    case (act)
                        `DIOS_ACT_HOLD:  next_out = dout[i];
                        `DIOS_ACT_FORCE: next_out = 1'b1;
                        default:         next_out = 1'b0;
                    endcase
                end
            end
        end

        always @(posedge clk or negedge rst_s_b) begin
            if (!rst_s_b) begin
                dout[i] <= 1'b0;
                cnt     <= {CW{1'b0}};
                flt_cnt <= 12'h000;
                flt     <= 1'b0;
                str_cnt <= 12'h000;
            end else begin
                dout[i] <= next_out;
                if (nv_restore_load) begin
                    cnt <= nv_restore_count[i*CW +: CW];
                end else if (rise[i] && cnt != {CW{1'b1}}) begin
                    cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
                end
                if (din_s[i] == flt) begin
                    flt_cnt <= 12'h000;
                end else if (tick) begin
                    if (flt_cnt + 12'h001 >= filt_t) begin
                        flt     <= din_s[i];
                        flt_cnt <= 12'h000;
                    end else begin
                        flt_cnt <= flt_cnt + 12'h001;
                    end
                end
                if (flt) begin
                    str_cnt <= str_t;
                end else if (tick && str_cnt != 12'h000) begin
                    str_cnt <= str_cnt - 12'h001;
                end
            end
        end

        assign din_out[i] = flt | (str_cnt != 12'h000);
        assign err_cnt[i] = lim_en & (cnt > lim_full);
        assign cnt_flat[i*CW +: CW] = cnt;
    end
endgenerate

endmodule // dios_top
